//--- hw/twi_consts.svh
// Offsets, control field positions, status codes and timing counts of the two-wire master.
// Assumes a 10 MHz core clock and 32-bit AXI4-Lite register words.
`ifndef TWI_CONSTS_SVH
`define TWI_CONSTS_SVH

`define TWI_OFS_CTRL 8'h00
`define TWI_OFS_STATUS 8'h04
`define TWI_OFS_DATA 8'h08
`define TWI_OFS_IRQ_STATUS 8'h0c
`define TWI_OFS_IRQ_MASK 8'h10

`define TWI_BIT_DONE 7
`define TWI_BIT_ACK 6
`define TWI_BIT_STA 5
`define TWI_BIT_STO 4
`define TWI_BIT_EN 2

`define TWI_ST_START 8'h08
`define TWI_ST_RSTART 8'h10
`define TWI_ST_AW_ACK 8'h18
`define TWI_ST_AW_NACK 8'h20
`define TWI_ST_TD_ACK 8'h28
`define TWI_ST_TD_NACK 8'h30
`define TWI_ST_ARB 8'h38
`define TWI_ST_AR_ACK 8'h40
`define TWI_ST_AR_NACK 8'h48
`define TWI_ST_RD_ACK 8'h50
`define TWI_ST_RD_NACK 8'h58
`define TWI_ST_IDLE 8'hf8

`define TWI_DATA_RESET 8'hff
`define TWI_CLK_NS 100
`define TWI_QUARTER_NS 200
`define TWI_QUARTER_CYC ((`TWI_QUARTER_NS + `TWI_CLK_NS - 1) / `TWI_CLK_NS)

`endif

//--- hw/twi_master_rx.sv
// Two-wire master controller with master-receive flow, AXI4-Lite registers and one interrupt.
// Assumes open-drain pads outside; scl and sda inputs are asynchronous and synchronised here.
//
// Implementation choices: register access over AXI4-Lite and the address map.
`default_nettype none
`include "twi_consts.svh"
// How it works
// - Wait for free bus, send START, set done flag, status 0x08.
// - Address read bit selects receive, write bit selects transmit operation.
// - After read address and acknowledge, set done with status 0x38, 0x40 or 0x48.
// - Each received byte appears in the data register when done sets.
// - Repeated START reports 0x10 and keeps the bus owned.
// - At 0x10 send loaded address; write direction switches to transmit.
// - At 0x40 or 0x50 clearing done receives byte, ACK per enable.
// - At 0x48 or 0x58 act on start/stop; stop request self-clears.
// - Byte received with NACK returned reports status 0x58.
// - Arbitration loss reports 0x38; without start, release bus and go idle.
// - At 0x38 with start request, send START once bus is free.
// - Arbitration loss in write address or data also reports 0x38.
module twi_master_rx (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    output logic irq
);
    function automatic twi_pkg::sel_t reg_sel(input logic [7:0] a);
        case (a)
            `TWI_OFS_CTRL: reg_sel = twi_pkg::SEL_CTRL;
            `TWI_OFS_STATUS: reg_sel = twi_pkg::SEL_STATUS;
            `TWI_OFS_DATA: reg_sel = twi_pkg::SEL_DATA;
            `TWI_OFS_IRQ_STATUS: reg_sel = twi_pkg::SEL_IRQ;
            `TWI_OFS_IRQ_MASK: reg_sel = twi_pkg::SEL_MASK;
            default: reg_sel = twi_pkg::SEL_NONE;
        endcase
    endfunction

    twi_pkg::ctrl_t ctrl;
    twi_pkg::state_t st;
    logic op_done;
    logic [7:0] status;
    logic [7:0] data;
    logic [1:0] irq_st;
    logic [1:0] irq_mask;
    logic [1:0] ph;
    logic [3:0] cnt;
    logic [8:0] sh;
    logic [8:0] samp;
    logic rx_mode;
    logic addr_ph;
    logic own;
    logic busy;
    logic arb_hold;
    logic sda_q;
    logic [1:0] line_s;
    logic tick;

    twi_sync2 u_sync (
        .core_clk(core_clk),
        .nrst(nrst),
        .d({scl_i, sda_i}),
        .q(line_s)
    );
    twi_tick u_tick (
        .core_clk(core_clk),
        .nrst(nrst),
        .tick(tick)
    );

    wire scl_s = line_s[1];
    wire sda_s = line_s[0];
    wire start_det = scl_s & sda_q & ~sda_s;
    wire stop_det = scl_s & ~sda_q & sda_s;
    wire bus_free = ~busy & scl_s & sda_s;

    // Bus slave decode
    wire wr_fire = s_axi_awready & s_axi_awvalid;
    wire rd_fire = s_axi_arready & s_axi_arvalid;
    twi_pkg::sel_t wsel;
    twi_pkg::sel_t rsel;
    assign wsel = reg_sel(s_axi_awaddr);
    assign rsel = reg_sel(s_axi_araddr);
    wire wlane = wr_fire & s_axi_wstrb[0];
    wire wr_ctrl = wlane & (wsel == twi_pkg::SEL_CTRL);
    wire w_sta = s_axi_wdata[`TWI_BIT_STA];
    wire w_sto = s_axi_wdata[`TWI_BIT_STO];
    wire w_ack = s_axi_wdata[`TWI_BIT_ACK];

    // Bit engine events
    wire adv = tick & ((ph != 2'd2) | scl_s);
    wire check = (rx_mode & ~addr_ph) ? (cnt == 4'd8) : (cnt != 4'd8);
    wire lost = (st == twi_pkg::ST_BIT) & adv & (ph == 2'd2) & check & sh[8] & ~sda_s;
    wire byte_end = (st == twi_pkg::ST_BIT) & adv & (ph == 2'd3) & (cnt == 4'd8);
    wire start_end = (st == twi_pkg::ST_START) & adv & (ph == 2'd3);
    wire stop_end = (st == twi_pkg::ST_STOP) & adv & (ph == 2'd3);
    wire set_done = byte_end | start_end | lost;
    wire go = wr_ctrl & s_axi_wdata[`TWI_BIT_DONE] & s_axi_wdata[`TWI_BIT_EN] & ~set_done;
    wire ack_seen = ~samp[0];
    wire [7:0] rx_byte = samp[8:1];
    wire sent_nack = sh[8];

    logic [7:0] next_status;
    assign next_status = addr_ph ? (rx_mode ? (ack_seen ? `TWI_ST_AR_ACK : `TWI_ST_AR_NACK)
                                            : (ack_seen ? `TWI_ST_AW_ACK : `TWI_ST_AW_NACK))
                                 : (rx_mode ? (sent_nack ? `TWI_ST_RD_NACK : `TWI_ST_RD_ACK)
                                            : (ack_seen ? `TWI_ST_TD_ACK : `TWI_ST_TD_NACK));
    wire at_addr = (status == `TWI_ST_START) | (status == `TWI_ST_RSTART);
    wire at_rx = (status == `TWI_ST_AR_ACK) | (status == `TWI_ST_RD_ACK);
    wire at_tx = (status == `TWI_ST_AW_ACK) | (status == `TWI_ST_AW_NACK)
               | (status == `TWI_ST_TD_ACK) | (status == `TWI_ST_TD_NACK);
    wire [1:0] next_irq_st = (irq_st & ~((wlane & (wsel == twi_pkg::SEL_IRQ)) ? s_axi_wdata[1:0] : 2'b00))
                           | {lost, set_done};

    logic [31:0] rd_val;
    assign rd_val = (rsel == twi_pkg::SEL_CTRL) ? {24'h000000, op_done, ctrl.ack_en, ctrl.sta, ctrl.sto,
                                                   1'b0, ctrl.en, 2'b00} :
                    (rsel == twi_pkg::SEL_STATUS) ? {24'h000000, status[7:3], 3'b000} :
                    (rsel == twi_pkg::SEL_DATA) ? {24'h000000, data} :
                    (rsel == twi_pkg::SEL_IRQ) ? {30'h00000000, irq_st} :
                    (rsel == twi_pkg::SEL_MASK) ? {30'h00000000, irq_mask} : 32'h00000000;

    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= 2'b00;
            s_axi_rdata <= 32'h00000000;
        end
        else
        begin
            s_axi_awready <= s_axi_awvalid & s_axi_wvalid & ~s_axi_awready & ~s_axi_bvalid;
            s_axi_wready <= s_axi_awvalid & s_axi_wvalid & ~s_axi_awready & ~s_axi_bvalid;
            if (wr_fire)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (wsel == twi_pkg::SEL_NONE) ? 2'b10 : 2'b00;
            end
            else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
            s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
            if (rd_fire)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_val;
                s_axi_rresp <= (rsel == twi_pkg::SEL_NONE) ? 2'b10 : 2'b00;
            end
            else if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

    // Control, flag and interrupt registers
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            ctrl <= '0;
            op_done <= 1'b0;
            irq_st <= 2'b00;
            irq_mask <= 2'b00;
            irq <= 1'b0;
            busy <= 1'b0;
            sda_q <= 1'b1;
        end
        else
        begin
            sda_q <= sda_s;
            busy <= start_det | (busy & ~stop_det);
            if (wr_ctrl)
                ctrl <= '{en: s_axi_wdata[`TWI_BIT_EN], ack_en: w_ack, sta: w_sta, sto: w_sto};
            else if (stop_end)
                ctrl.sto <= 1'b0;
            // Hardware set beats a same-cycle software clear
            op_done <= set_done | (op_done & ~go);
            irq_st <= next_irq_st;
            if (wlane & (wsel == twi_pkg::SEL_MASK))
                irq_mask <= s_axi_wdata[1:0];
            irq <= |(irq_st & irq_mask);
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            st <= twi_pkg::ST_IDLE;
            status <= `TWI_ST_IDLE;
            data <= `TWI_DATA_RESET;
            ph <= 2'd0;
            cnt <= 4'd0;
            sh <= 9'h1ff;
            samp <= 9'h000;
            rx_mode <= 1'b0;
            addr_ph <= 1'b0;
            own <= 1'b0;
            arb_hold <= 1'b0;
            scl_oe <= 1'b0;
            sda_oe <= 1'b0;
            scl_o <= 1'b0;
            sda_o <= 1'b0;
        end
        else
        begin
            if (wlane & (wsel == twi_pkg::SEL_DATA))
                data <= s_axi_wdata[7:0];
            if (!ctrl.en && !go)
            begin
                // Disabling drops the bus at once; a half-sent byte is abandoned
                st <= twi_pkg::ST_IDLE;
                scl_oe <= 1'b0;
                sda_oe <= 1'b0;
                own <= 1'b0;
                arb_hold <= 1'b0;
            end
            else
            begin
                if (adv && (st == twi_pkg::ST_START || st == twi_pkg::ST_BIT || st == twi_pkg::ST_STOP))
                    ph <= ph + 2'd1;
                case (st)
                    twi_pkg::ST_IDLE:
                    begin
                        if (go && w_sta)
                            st <= twi_pkg::ST_WAIT_FREE;
                    end
                    // start only on a free bus
                    twi_pkg::ST_WAIT_FREE:
                    begin
                        if (tick && bus_free)
                        begin
                            st <= twi_pkg::ST_START;
                            ph <= 2'd0;
                        end
                    end
                    twi_pkg::ST_START:
                    begin
                        if (adv)
                        begin
                            case (ph)
                                2'd0: sda_oe <= 1'b0;
                                2'd1: scl_oe <= 1'b0;
                                2'd2: sda_oe <= 1'b1;
                                default:
                                begin
                                    scl_oe <= 1'b1;
                                    status <= own ? `TWI_ST_RSTART : `TWI_ST_START;
                                    own <= 1'b1;
                                    st <= twi_pkg::ST_HOLD;
                                end
                            endcase
                        end
                    end
                    twi_pkg::ST_BIT:
                    begin
                        if (lost)
                        begin
                            scl_oe <= 1'b0;
                            sda_oe <= 1'b0;
                            own <= 1'b0;
                            arb_hold <= 1'b1;
                            status <= `TWI_ST_ARB;
                            st <= twi_pkg::ST_HOLD;
                        end
                        else if (adv)
                        begin
                            case (ph)
                                2'd0: sda_oe <= ~sh[8];
                                2'd1: scl_oe <= 1'b0;
                                2'd2: samp <= {samp[7:0], sda_s};
                                default:
                                begin
                                    scl_oe <= 1'b1;
                                    sh <= {sh[7:0], 1'b1};
                                    cnt <= cnt + 4'd1;
                                    if (cnt == 4'd8)
                                    begin
                                        if (rx_mode && !addr_ph)
                                            data <= rx_byte;
                                        status <= next_status;
                                        st <= twi_pkg::ST_HOLD;
                                    end
                                end
                            endcase
                        end
                    end
                    twi_pkg::ST_HOLD:
                    begin
                        if (go)
                        begin
                            ph <= 2'd0;
                            cnt <= 4'd0;
                            if (at_addr)
                            begin
                                sh <= {data, 1'b1};
                                rx_mode <= data[0];
                                addr_ph <= 1'b1;
                                st <= twi_pkg::ST_BIT;
                            end
                            else if (arb_hold)
                            begin
                                arb_hold <= 1'b0;
                                st <= w_sta ? twi_pkg::ST_WAIT_FREE : twi_pkg::ST_IDLE;
                            end
                            else if (w_sto)
                                st <= twi_pkg::ST_STOP;
                            else if (w_sta)
                                st <= twi_pkg::ST_START;
                            else if (at_rx || at_tx)
                            begin
                                sh <= at_rx ? {8'hff, ~w_ack} : {data, 1'b1};
                                addr_ph <= 1'b0;
                                st <= twi_pkg::ST_BIT;
                            end
                        end
                    end
                    twi_pkg::ST_STOP:
                    begin
                        if (adv)
                        begin
                            case (ph)
                                2'd0: sda_oe <= 1'b1;
                                2'd1: scl_oe <= 1'b0;
                                2'd2: sda_oe <= 1'b1;
                                default:
                                begin
                                    sda_oe <= 1'b0;
                                    own <= 1'b0;
                                    status <= `TWI_ST_IDLE;
                                    st <= ctrl.sta ? twi_pkg::ST_WAIT_FREE : twi_pkg::ST_IDLE;
                                end
                            endcase
                        end
                    end
                    default: st <= twi_pkg::ST_IDLE;
                endcase
            end
        end
    end

    a_hold_stretch: assert property (@(posedge core_clk) disable iff (!nrst)
        (st == twi_pkg::ST_HOLD && op_done && !arb_hold && ctrl.en) |-> scl_oe)
        else $error("clock line not held low while done is set");
    a_start_status: assert property (@(posedge core_clk) disable iff (!nrst)
        (start_end && ctrl.en) |=> op_done && (status == `TWI_ST_START || status == `TWI_ST_RSTART))
        else $error("start did not report 0x08 or 0x10");
    a_rstart_owned: assert property (@(posedge core_clk) disable iff (!nrst)
        (start_end && ctrl.en && own) |=> status == `TWI_ST_RSTART && own)
        else $error("repeated start lost ownership or code");
    a_addr_status: assert property (@(posedge core_clk) disable iff (!nrst)
        (byte_end && ctrl.en && addr_ph && rx_mode) |=> status == `TWI_ST_AR_ACK || status == `TWI_ST_AR_NACK)
        else $error("read address status wrong");
    a_rx_data: assert property (@(posedge core_clk) disable iff (!nrst)
        (byte_end && ctrl.en && rx_mode && !addr_ph) |=> data == $past(rx_byte) && op_done)
        else $error("received byte not presented");
    a_nack_code: assert property (@(posedge core_clk) disable iff (!nrst)
        (byte_end && ctrl.en && rx_mode && !addr_ph && sh[8]) |=> status == `TWI_ST_RD_NACK)
        else $error("NACK byte did not give 0x58");
    a_ack_drive: assert property (@(posedge core_clk) disable iff (!nrst)
        (st == twi_pkg::ST_BIT && ph == 2'd2 && rx_mode && !addr_ph && cnt == 4'd8 && ctrl.en)
        |-> sda_oe == ~sh[8])
        else $error("acknowledge bit not driven as enabled");
    a_arb_release: assert property (@(posedge core_clk) disable iff (!nrst)
        (lost && ctrl.en) |=> status == `TWI_ST_ARB && !scl_oe && !sda_oe ##1 !scl_oe)
        else $error("arbitration loss did not release bus");
    a_free_start: assert property (@(posedge core_clk) disable iff (!nrst)
        (st == twi_pkg::ST_WAIT_FREE && ctrl.en ##1 st == twi_pkg::ST_START) |-> $past(bus_free))
        else $error("start issued on a busy bus");
    a_stop_clear: assert property (@(posedge core_clk) disable iff (!nrst)
        (stop_end && !wr_ctrl && ctrl.en) |=> !ctrl.sto)
        else $error("stop request did not self-clear");
    a_mode_dir: assert property (@(posedge core_clk) disable iff (!nrst)
        (st == twi_pkg::ST_HOLD && go && at_addr && ctrl.en) |=> rx_mode == $past(data[0]))
        else $error("direction bit did not select operation");
endmodule
`default_nettype wire

//--- hw/twi_pkg.sv
// Types shared by the two-wire master files.
// Assumes twi_consts.svh for all numeric values.
`default_nettype none
package twi_pkg;
    typedef enum logic [2:0] {ST_IDLE, ST_WAIT_FREE, ST_START, ST_BIT, ST_HOLD, ST_STOP} state_t;
    typedef struct packed {
        logic en;
        logic ack_en;
        logic sta;
        logic sto;
    } ctrl_t;
    typedef enum logic [2:0] {SEL_CTRL, SEL_STATUS, SEL_DATA, SEL_IRQ, SEL_MASK, SEL_NONE} sel_t;
endpackage
`default_nettype wire

//--- hw/twi_sync2.sv
// Two-flop synchroniser for the bus lines.
// Assumes asynchronous inputs; only the second flop is read outside.
`default_nettype none
module twi_sync2 (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [1:0] d,
    output logic [1:0] q
);
    logic [1:0] meta;
    genvar i;
    generate
        for (i = 0; i < 2; i++)
        begin : g_bit
            always_ff @(posedge core_clk)
            begin
                if (!nrst)
                begin
                    meta[i] <= 1'b1;
                    q[i] <= 1'b1;
                end
                else
                begin
                    meta[i] <= d[i];
                    q[i] <= meta[i];
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

//--- hw/twi_tick.sv
// Quarter-bit enable pulse divider for the bus timing.
// Assumes core_clk at the rate set in twi_consts.svh.
`default_nettype none
`include "twi_consts.svh"
module twi_tick (
    input wire logic core_clk,
    input wire logic nrst,
    output logic tick
);
    localparam logic [7:0] LAST = 8'(`TWI_QUARTER_CYC - 1);
    logic [7:0] cnt;
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            cnt <= 8'h00;
            tick <= 1'b0;
        end
        else
        begin
            cnt <= (cnt == LAST) ? 8'h00 : cnt + 8'h01;
            tick <= (cnt == LAST);
        end
    end
endmodule
`default_nettype wire

//--- testbench/twi_slave_model.sv
// Slave transmitter model on the two-wire bus.
// Assumes the bench resolves pulled-up lines.
`default_nettype none
module twi_slave_model #(parameter logic [6:0] ADDR = 7'h2a) (
    input wire logic scl,
    input wire logic sda,
    output logic sda_pull
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] sh = 8'h00;
    logic [7:0] tx = 8'ha5;
    logic act = 1'b0;
    logic rdp = 1'b0;
    int cnt = 0;
    initial sda_pull = 1'b0;
    // Any sda edge with scl high is a start or a stop
    always @(sda)
        if (scl)
        begin
            act = !sda;
            rdp = 1'b0;
            cnt = 0;
        end
    always @(posedge scl)
        if (act && cnt < 8)
        begin
            sh = rdp ? sh : {sh[6:0], sda};
            cnt++;
        end
        else if (act)
        begin
            act = rdp ? !sda : (sh[7:1] == ADDR);
            tx = rdp ? tx + 8'h01 : tx;
            rdp = rdp | sh[0];
            cnt = 0;
        end
    always @(negedge scl)
        sda_pull = act && (rdp ? (cnt < 8 && !tx[7 - cnt]) : (cnt == 8 && sh[7:1] == ADDR));
endmodule
`default_nettype wire

//--- testbench/two_wire_master_receiver_bench.sv
// Bench: AXI4-Lite tasks run a receive transfer against the slave model.
// Assumes a 100 ns core clock and pulled-up bus lines.
`default_nettype none
`include "twi_consts.svh"
module two_wire_master_receiver_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0, rdata, v;
    logic awready, wready, bvalid, arready, rvalid, scl_oe, sda_oe, irq, pull;
    logic jam = 1'b0;
    logic [1:0] bresp, rresp, resp;
    int bad_count = 0, comparisons = 0;
    wire logic scl = ~scl_oe;
    wire logic sda = ~(sda_oe | pull | jam);
    always #50 core_clk = ~core_clk;
    twi_master_rx dut (.core_clk(core_clk), .nrst(nrst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .scl_i(scl), .scl_o(),
        .scl_oe(scl_oe), .sda_i(sda), .sda_o(), .sda_oe(sda_oe), .irq(irq));
    twi_slave_model slv (.scl(scl), .sda(sda), .sda_pull(pull));
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        comparisons++;
        if (s !== e)
        begin
            bad_count++;
            $display("unexpected %s: expected %h, seen %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'h7};
        do @(posedge core_clk); while (awready !== 1'b1);
        {awvalid, wvalid} <= 2'h0;
        while (bvalid !== 1'b1) @(posedge core_clk);
        resp = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge core_clk);
        {araddr, arvalid, rready} <= {a, 2'h3};
        do @(posedge core_clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1) @(posedge core_clk);
        {v, resp} = {rdata, rresp};
        rready <= 1'b0;
    endtask
    task automatic step(input logic [7:0] c, input logic [7:0] st);
        wr(`TWI_OFS_CTRL, {24'h0, c});
        v = 32'h0;
        while (v[7] !== 1'b1) rd(`TWI_OFS_CTRL);
        rd(`TWI_OFS_STATUS);
        chk("status", {24'h0, st}, v);
        chk("scl_oe", 32'h1, {31'h0, scl_oe});
    endtask
    task automatic finish_test;
        $display("comparisons %0d, mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial
    begin
        #1000000;
        bad_count++;
        finish_test();
    end
    initial
    begin
        repeat (10) @(posedge core_clk);
        nrst <= 1'b1;
        rd(`TWI_OFS_STATUS);
        chk("idle status", 32'hf8, v);
        rd(`TWI_OFS_DATA);
        chk("data reset", 32'hff, v);
        rd(8'h14);
        chk("unmapped", 32'h2, {30'h0, resp});
        wr(8'h14, 32'h1);
        chk("write unmapped", 32'h2, {30'h0, resp});
        wr(`TWI_OFS_IRQ_MASK, 32'h1);
        chk("bresp", 32'h0, {30'h0, resp});
        step(8'ha4, `TWI_ST_START);
        chk("irq", 32'h1, {31'h0, irq});
        wr(`TWI_OFS_DATA, 32'h55);
        step(8'hc4, `TWI_ST_AR_ACK);
        step(8'hc4, `TWI_ST_RD_ACK);
        rd(`TWI_OFS_DATA);
        chk("byte", 32'ha5, v);
        step(8'h84, `TWI_ST_RD_NACK);
        rd(`TWI_OFS_DATA);
        chk("byte", 32'ha6, v);
        $display("test receive done");
        step(8'ha4, `TWI_ST_RSTART);
        wr(`TWI_OFS_DATA, 32'h33);
        step(8'h84, `TWI_ST_AR_NACK);
        step(8'hb4, `TWI_ST_START);
        wr(`TWI_OFS_DATA, 32'h55);
        step(8'h84, `TWI_ST_AR_ACK);
        step(8'h84, `TWI_ST_RD_NACK);
        wr(`TWI_OFS_CTRL, 32'h94);
        while (v !== 32'hf8) rd(`TWI_OFS_STATUS);
        rd(`TWI_OFS_CTRL);
        chk("stop bit", 32'h0, {31'h0, v[4]});
        chk("scl_oe", 32'h0, {31'h0, scl_oe});
        $display("test restart and stop done");
        step(8'ha4, `TWI_ST_START);
        wr(`TWI_OFS_DATA, 32'h55);
        jam <= 1'b1;
        wr(`TWI_OFS_CTRL, 32'hc4);
        v = 32'h0;
        while (v[7] !== 1'b1) rd(`TWI_OFS_CTRL);
        rd(`TWI_OFS_STATUS);
        chk("lost status", 32'h38, v);
        chk("lost scl_oe", 32'h0, {31'h0, scl_oe});
        jam <= 1'b0;
        step(8'ha4, `TWI_ST_START);
        $display("test arbitration done");
        wr(`TWI_OFS_IRQ_MASK, 32'h0);
        @(posedge core_clk);
        chk("irq masked", 32'h0, {31'h0, irq});
        wr(`TWI_OFS_IRQ_MASK, 32'h1);
        wr(`TWI_OFS_IRQ_STATUS, 32'h1);
        @(posedge core_clk);
        chk("irq cleared", 32'h0, {31'h0, irq});
        rd(`TWI_OFS_IRQ_STATUS);
        chk("irq status", 32'h0, {31'h0, v[0]});
        chk("lost event", 32'h1, {31'h0, v[1]});
        $display("test interrupt done");
        finish_test();
    end
endmodule
`default_nettype wire
